// ===== rtl/fsp_pkg.sv
// Constants, types and state records of the flash status host controller
package fsp_pkg;

   // Clock and flash bus timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int T_WE_LOW_NS   = 60;  // Write strobe low time
   localparam int T_WE_HIGH_NS  = 40;  // Write strobe recovery
   localparam int T_RD_ACC_NS   = 70;  // Output enable to data valid
   localparam int SYNC_STAGES   = 2;   // Data pins pass two flip-flops
   localparam logic [3:0] WE_LOW_CYC =
      4'((T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] WE_HIGH_CYC =
      4'((T_WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] RD_CYC =
      4'((T_RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
   localparam logic [3:0] BUF_RETRY_MAX = 4'h8;

   // Flash command codes
   localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
   localparam logic [15:0] CMD_BUF_PROGRAM = 16'h00E8;
   localparam logic [15:0] CMD_READ_ID     = 16'h0090;
   localparam logic [21:0] PCR_WORD_OFFSET = 22'h00_0006;

   // Flash status word fields
   localparam int SR_READY     = 7;
   localparam int SR_ERASE_ERR = 5;
   localparam int SR_PROG_ERR  = 4;
   localparam logic [15:0] SR_VALID_MASK  = 16'h00FE;
   localparam logic [15:0] SR_READY_MASK  = 16'h0080;
   localparam int XSR_AVAIL    = 7;
   localparam logic [15:0] XSR_VALID_MASK = 16'h0080;
   localparam int PCR_LSB      = 8;

   // Own register offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_STATE  = 8'h08;
   localparam logic [7:0] OFS_SR     = 8'h0C;
   localparam logic [7:0] OFS_XSR    = 8'h10;
   localparam logic [7:0] OFS_LAYOUT = 8'h14;
   localparam int CTRL_GO_BIT = 8;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operations that software orders
   typedef enum logic [1:0] {
      OP_STATUS = 2'b00,
      OP_POLL   = 2'b01,
      OP_BUFCHK = 2'b10,
      OP_LAYOUT = 2'b11
   } fsp_op_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_CMD_LO  = 3'b001,
      ST_CMD_HI  = 3'b010,
      ST_RD_LO   = 3'b011,
      ST_RD_HI   = 3'b100,
      ST_EVAL    = 3'b101
   } fsp_state_t;

   // Flash pins driven by the host
   typedef struct packed {
      logic [21:0] addr;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
      logic [15:0] dq_out;
      logic        dq_oe;
   } fsp_pins_t;

   // Controller state
   typedef struct packed {
      fsp_state_t  st;
      fsp_op_t     op;
      logic [21:0] base;
      logic [3:0]  cnt;
      logic [3:0]  retry;
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [15:0] word;
      logic        busy;
      logic        done;
      logic        buf_fail;
      logic        bad_seq;
      logic [15:0] sr;
      logic [15:0] extended_status_word;
      logic [2:0]  layout;
      fsp_pins_t   pins;
   } fsp_ctl_t;

   // Register slave state
   typedef struct packed {
      logic        aw_have;
      logic [7:0]  awaddr;
      logic        w_have;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } fsp_slv_t;

endpackage

// ===== rtl/fsp_axi_slave.sv
// AXI4-Lite slave front end for the controller registers
`timescale 1ns/1ps
module fsp_axi_slave (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // Register side
   output logic             wr_en,
   output logic [7:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic [3:0]       wr_strb,
   input  wire logic        wr_ok,
   output logic [7:0]       rd_addr,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_ok
);

   fsp_pkg::fsp_slv_t r;
   fsp_pkg::fsp_slv_t next_r;

   // Handshake outputs
   assign s_awready = !r.aw_have && !r.bvalid;
   assign s_wready  = !r.w_have && !r.bvalid;
   assign s_arready = !r.rvalid;
   assign s_bvalid  = r.bvalid;
   assign s_bresp   = r.bresp;
   assign s_rvalid  = r.rvalid;
   assign s_rdata   = r.rdata;
   assign s_rresp   = r.rresp;
   assign wr_en     = r.aw_have && r.w_have && !r.bvalid;
   assign wr_addr   = r.awaddr;
   assign wr_data   = r.wdata;
   assign wr_strb   = r.wstrb;
   assign rd_addr   = s_araddr;

   // Channel bookkeeping
   always_comb begin
      next_r = r;
      if (s_awvalid && s_awready) begin
         next_r.aw_have = 1'b1;
         next_r.awaddr  = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         next_r.w_have = 1'b1;
         next_r.wdata  = s_wdata;
         next_r.wstrb  = s_wstrb;
      end
      if (wr_en) begin
         next_r.aw_have = 1'b0;
         next_r.w_have  = 1'b0;
         next_r.bvalid  = 1'b1;
         next_r.bresp   = wr_ok ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
      end else if (r.bvalid && s_bready) begin
         next_r.bvalid = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         next_r.rvalid = 1'b1;
         next_r.rdata  = rd_data;
         next_r.rresp  = rd_ok ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
      end else if (r.rvalid && s_rready) begin
         next_r.rvalid = 1'b0;
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule

// ===== rtl/fsp_host.sv
// Host controller that reads partition status words from the flash
//
// Functional notes
// - Host masks status bits 15-8 and 0
// - Status covers addressed partition, engine maybe shared
// - Bits 6-1 meaningless while not ready
// - Reissue buffer command until buffer available; host reissues at most 8 times, then sets buf_fail
// - Host masks extended bits except bit 7
// - Host masks configuration bits except 10-8
`timescale 1ns/1ps
module fsp_host (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite register port
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // Flash parallel bus
   output fsp_pkg::fsp_pins_t flash_pins,
   input  wire logic [15:0] flash_dq_in
);

   fsp_pkg::fsp_ctl_t r;
   fsp_pkg::fsp_ctl_t next_r;

   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_ok;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_ok;

   // Partition count minus one for a layout code
   function automatic logic [1:0] parts_m1(input logic [2:0] lay);
      case (lay)
         3'b000:  parts_m1 = 2'd0;
         3'b001, 3'b010, 3'b100: parts_m1 = 2'd1;
         3'b011, 3'b101, 3'b110: parts_m1 = 2'd2;
         3'b111:  parts_m1 = 2'd3;
         default: parts_m1 = 2'd0;
      endcase
   endfunction

   // Byte lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = val[i*8 +: 8];
         end
      end
      merge = res;
   endfunction

   fsp_axi_slave u_slave (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .wr_en     (wr_en),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .wr_strb   (wr_strb),
      .wr_ok     (wr_ok),
      .rd_addr   (rd_addr),
      .rd_data   (rd_data),
      .rd_ok     (rd_ok)
   );

   assign flash_pins = r.pins;
   assign wr_ok = (wr_addr == fsp_pkg::OFS_CTRL) ||
                  (wr_addr == fsp_pkg::OFS_ADDR);

   // Register read decode
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (rd_addr)
         fsp_pkg::OFS_CTRL:  rd_data = {30'h0000_0000, r.op};
         fsp_pkg::OFS_ADDR:  rd_data = {10'h000, r.base};
         fsp_pkg::OFS_STATE: rd_data = {28'h000_0000, r.bad_seq,
                                        r.buf_fail, r.done, r.busy};
         fsp_pkg::OFS_SR:    rd_data = {16'h0000, r.sr};
         fsp_pkg::OFS_XSR:   rd_data = {16'h0000, r.extended_status_word};
         fsp_pkg::OFS_LAYOUT: begin
            rd_data[2:0] = r.layout;
            rd_data[5:4] = parts_m1(r.layout);
            rd_data[8]   = parts_m1(r.layout) != 2'd0;
            rd_data[9]   = parts_m1(r.layout) != 2'd0;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   // Sequencer for flash command and read cycles
   always_comb begin
      logic [31:0] ctrl;
      logic [15:0] w;
      ctrl   = 32'h0000_0000;
      w      = 16'h0000;
      next_r = r;
      next_r.sync1 = flash_dq_in;
      next_r.sync2 = r.sync1;
      if (r.cnt != 4'h0) begin
         next_r.cnt = r.cnt - 4'h1;
      end
      // Software writes
      if (wr_en && wr_addr == fsp_pkg::OFS_ADDR) begin
         next_r.base = 22'(merge({10'h000, r.base}, wr_data, wr_strb));
      end
      if (wr_en && wr_addr == fsp_pkg::OFS_CTRL) begin
         ctrl = merge({30'h0000_0000, r.op}, wr_data, wr_strb);
         if (!r.busy) begin
            next_r.op = fsp_pkg::fsp_op_t'(ctrl[1:0]);
         end
         if (!r.busy && wr_strb[1] && ctrl[fsp_pkg::CTRL_GO_BIT]) begin
            next_r.busy     = 1'b1;
            next_r.done     = 1'b0;
            next_r.buf_fail = 1'b0;
            next_r.bad_seq  = 1'b0;
            next_r.retry    = fsp_pkg::BUF_RETRY_MAX;
            next_r.st       = fsp_pkg::ST_CMD_LO;
            next_r.cnt      = fsp_pkg::WE_LOW_CYC;
         end
      end
      case (r.st)
         fsp_pkg::ST_IDLE: begin
            next_r.pins.ce_n  = 1'b1;
            next_r.pins.oe_n  = 1'b1;
            next_r.pins.we_n  = 1'b1;
            next_r.pins.dq_oe = 1'b0;
         end
         fsp_pkg::ST_CMD_LO: begin
            next_r.pins.addr  = r.base;
            next_r.pins.ce_n  = 1'b0;
            next_r.pins.we_n  = 1'b0;
            next_r.pins.dq_oe = 1'b1;
            case (r.op)
               fsp_pkg::OP_BUFCHK:
                  next_r.pins.dq_out = fsp_pkg::CMD_BUF_PROGRAM;
               fsp_pkg::OP_LAYOUT:
                  next_r.pins.dq_out = fsp_pkg::CMD_READ_ID;
               default:
                  next_r.pins.dq_out = fsp_pkg::CMD_READ_STATUS;
            endcase
            if (r.cnt == 4'h0 && !r.pins.we_n) begin
               next_r.pins.we_n = 1'b1;
               next_r.st        = fsp_pkg::ST_CMD_HI;
               next_r.cnt       = fsp_pkg::WE_HIGH_CYC;
            end
         end
         fsp_pkg::ST_CMD_HI: begin
            next_r.pins.ce_n  = 1'b1;
            if (r.cnt == 4'h0) begin
               next_r.pins.dq_oe = 1'b0;
               next_r.st         = fsp_pkg::ST_RD_LO;
               next_r.cnt        = fsp_pkg::RD_CYC;
            end
         end
         fsp_pkg::ST_RD_LO: begin
            if (r.op == fsp_pkg::OP_LAYOUT) begin
               next_r.pins.addr = r.base + fsp_pkg::PCR_WORD_OFFSET;
            end
            next_r.pins.ce_n = 1'b0;
            next_r.pins.oe_n = 1'b0;
            if (r.cnt == 4'h0 && !r.pins.oe_n) begin
               next_r.word      = r.sync2;
               next_r.pins.ce_n = 1'b1;
               next_r.pins.oe_n = 1'b1;
               next_r.st        = fsp_pkg::ST_RD_HI;
               next_r.cnt       = fsp_pkg::WE_HIGH_CYC;
            end
         end
         fsp_pkg::ST_RD_HI: begin
            if (r.cnt == 4'h0) begin
               next_r.st = fsp_pkg::ST_EVAL;
            end
         end
         fsp_pkg::ST_EVAL: begin
            next_r.st   = fsp_pkg::ST_IDLE;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
            case (r.op)
               fsp_pkg::OP_STATUS, fsp_pkg::OP_POLL: begin
                  w = r.word & fsp_pkg::SR_VALID_MASK;
                  if (!w[fsp_pkg::SR_READY]) begin
                     w = w & fsp_pkg::SR_READY_MASK;
                  end
                  next_r.sr = w;
                  next_r.bad_seq = w[fsp_pkg::SR_ERASE_ERR] &&
                                   w[fsp_pkg::SR_PROG_ERR];
                  if (r.op == fsp_pkg::OP_POLL &&
                      !w[fsp_pkg::SR_READY]) begin
                     // Read again without reissuing the command
                     next_r.st   = fsp_pkg::ST_RD_LO;
                     next_r.cnt  = fsp_pkg::RD_CYC;
                     next_r.busy = 1'b1;
                     next_r.done = 1'b0;
                  end
               end
               fsp_pkg::OP_BUFCHK: begin
                  next_r.extended_status_word = r.word & fsp_pkg::XSR_VALID_MASK;
                  if (!r.word[fsp_pkg::XSR_AVAIL]) begin
                     if (r.retry != 4'h0) begin
                        next_r.retry = r.retry - 4'h1;
                        next_r.st    = fsp_pkg::ST_CMD_LO;
                        next_r.cnt   = fsp_pkg::WE_LOW_CYC;
                        next_r.busy  = 1'b1;
                        next_r.done  = 1'b0;
                     end else begin
                        next_r.buf_fail = 1'b1;
                     end
                  end
               end
               default: begin
                  next_r.layout = r.word[fsp_pkg::PCR_LSB +: 3];
               end
            endcase
         end
         default: next_r.st = fsp_pkg::ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r           <= '0;
         r.pins.ce_n <= 1'b1;
         r.pins.oe_n <= 1'b1;
         r.pins.we_n <= 1'b1;
         r.layout    <= 3'b001;
      end else begin
         r <= next_r;
      end
   end

endmodule

// ===== tb/fsp_flash_model.sv
// Behavioural flash device with status, buffer and layout words
`timescale 1ns/1ps
module fsp_flash_model (
   // Host side pins
   input  wire fsp_pkg::fsp_pins_t pins,
   output logic [15:0]             dq,
   // Contents chosen by the scenario
   input  wire logic [15:0]        sr_val,
   input  wire logic [15:0]        xsr_val,
   input  wire logic [15:0]        pcr_val,
   input  wire logic [3:0]         busy_reads,
   input  wire logic [3:0]         buf_after,
   input  wire logic               clr
);
   logic [15:0] cmd    = 16'h0000;
   logic [15:0] word   = 16'h0000;
   logic [3:0]  e8_cnt = 4'h0;
   logic [3:0]  rd_cnt = 4'h0;
   logic [3:0]  rd_base = 4'h0;  // Read count at the latest command
   logic        rdy;
   logic        avail;
   // Ready after some reads, buffer after some requests
   assign rdy   = sr_val[7] && (4'(rd_cnt - rd_base) >= busy_reads);
   assign avail = e8_cnt > buf_after;
   // Command latch; buffer requests counted until cleared
   always @(negedge pins.we_n or posedge clr) begin
      if (clr) begin
         e8_cnt <= 4'h0;
      end else begin
         cmd     <= pins.dq_out;
         rd_base <= rd_cnt;
         if (pins.dq_out == fsp_pkg::CMD_BUF_PROGRAM) begin
            e8_cnt <= e8_cnt + 4'h1;
         end
      end
   end
   // Word chosen as the read strobe falls
   always @(negedge pins.oe_n) begin
      rd_cnt <= rd_cnt + 4'h1;
      if (cmd == fsp_pkg::CMD_READ_STATUS) begin
         word <= {sr_val[15:8], rdy, sr_val[6:0]};
      end else if (cmd == fsp_pkg::CMD_BUF_PROGRAM) begin
         word <= {xsr_val[15:8], avail, xsr_val[6:0]};
      end else begin
         word <= (pins.addr[2:0] == 3'h6) ? pcr_val : 16'h0000;
      end
   end
   // Released bus shows the inverse of the last word
   assign dq = (!pins.ce_n && !pins.oe_n) ? word : ~word;
endmodule

// ===== tb/fsp_host_properties.sv
// Port checks for the flash status host controller
`timescale 1ns/1ps
module fsp_host_properties (
   // Clock and reset
   input wire logic               aclk,
   input wire logic               aresetn,
   // Register port handshakes
   input wire logic               s_awvalid,
   input wire logic               s_awready,
   input wire logic               s_wvalid,
   input wire logic               s_wready,
   input wire logic               s_bvalid,
   input wire logic               s_arvalid,
   input wire logic               s_arready,
   input wire logic               s_rvalid,
   input wire logic               s_rready,
   input wire logic [31:0]        s_rdata,
   // Flash pins
   input wire fsp_pkg::fsp_pins_t flash_pins
);
   default clocking dcb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Register port answers
   read_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read answer late");
   read_hold_a: assert property (s_rvalid && !s_rready
      |=> s_rvalid && $stable(s_rdata))
      else $error("read answer dropped");
   read_block_a: assert property (s_rvalid |-> !s_arready)
      else $error("address taken while answer pending");
   write_answer_a: assert property (s_awvalid && s_awready && s_wvalid
      && s_wready |-> ##2 s_bvalid)
      else $error("write answer late");
   // Flash strobe shapes
   strobe_len_a: assert property ($fell(flash_pins.we_n)
      |-> !flash_pins.we_n [*3] ##1 flash_pins.we_n)
      else $error("write strobe length wrong");
   read_len_a: assert property ($fell(flash_pins.oe_n)
      |-> !flash_pins.oe_n [*6] ##1 flash_pins.oe_n)
      else $error("read strobe length wrong");
   drive_excl_a: assert property (!flash_pins.we_n
      |-> flash_pins.dq_oe && !flash_pins.ce_n && flash_pins.oe_n)
      else $error("command cycle drive wrong");
   cmd_hold_a: assert property (!flash_pins.we_n
      && !$past(flash_pins.we_n) |-> $stable(flash_pins.dq_out)
      && $stable(flash_pins.addr))
      else $error("command moved during strobe");
   // Main traffic seen
   cover property ($fell(flash_pins.we_n));
   cover property ($fell(flash_pins.oe_n));
   cover property (s_rvalid && s_rready);
endmodule
bind fsp_host fsp_host_properties i_fsp_host_properties (
   .aclk, .aresetn, .s_awvalid, .s_awready, .s_wvalid, .s_wready,
   .s_bvalid, .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata,
   .flash_pins
);

// ===== tb/fsp_host_tb_top.sv
// Self-checking bench for the flash status host controller
`timescale 1ns/1ps
module fsp_host_tb_top;
   localparam int LIMIT = 20000;
   logic               aclk = 1'b0;
   logic               aresetn = 1'b0;
   logic [7:0]         s_awaddr = 8'h00;
   logic [7:0]         s_araddr = 8'h00;
   logic [31:0]        s_wdata = 32'h0000_0000;
   logic [3:0]         s_wstrb = 4'hF;
   logic               s_awvalid = 1'b0;
   logic               s_wvalid = 1'b0;
   logic               s_bready = 1'b0;
   logic               s_arvalid = 1'b0;
   logic               s_rready = 1'b0;
   logic               s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0]         s_bresp, s_rresp, rs;
   logic [31:0]        s_rdata, rv;
   fsp_pkg::fsp_pins_t flash_pins;
   logic [15:0]        flash_dq_in, dq_dev;
   logic [15:0]        sr_val = 16'h0000;
   logic [15:0]        xsr_val = 16'h0000;
   logic [15:0]        pcr_val = 16'h0000;
   logic [3:0]         busy_reads = 4'h0;
   logic [3:0]         buf_after = 4'h0;
   logic               clr = 1'b0;
   int                 failures = 0;
   int                 cmp_count = 0;
   int                 cyc = 0;
   // Clock and the shared data wire
   always #10 aclk = ~aclk;
   assign flash_dq_in = flash_pins.dq_oe ? flash_pins.dq_out : dq_dev;
   // Controller and flash device
   fsp_host i_fsp_host (
      .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
      .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
      .s_rready, .flash_pins, .flash_dq_in
   );
   fsp_flash_model i_fsp_flash_model (
      .pins(flash_pins), .dq(dq_dev), .sr_val, .xsr_val, .pcr_val,
      .busy_reads, .buf_after, .clr
   );
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One register write or read, waiting for its answer
   task automatic axi(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      logic ta, tw, tr, dn;
      @(posedge aclk);
      s_awaddr  <= a;
      s_araddr  <= a;
      s_wdata   <= d;
      s_awvalid <= wr;
      s_wvalid  <= wr;
      s_arvalid <= !wr;
      s_bready  <= wr;
      s_rready  <= !wr;
      do begin
         @(negedge aclk);
         ta = s_awvalid && s_awready;
         tw = s_wvalid && s_wready;
         tr = s_arvalid && s_arready;
         dn = wr ? s_bvalid : s_rvalid;
         rs = wr ? s_bresp : s_rresp;
         rv = s_rdata;
         @(posedge aclk);
         if (ta) s_awvalid <= 1'b0;
         if (tw) s_wvalid <= 1'b0;
         if (tr) s_arvalid <= 1'b0;
      end while (!dn);
      s_bready <= 1'b0;
      s_rready <= 1'b0;
   endtask
   // Start an operation and wait until it is no longer busy
   task automatic run_op(input logic [1:0] op);
      axi(1'b1, fsp_pkg::OFS_CTRL, {23'h0, 1'b1, 6'h0, op});
      axi(1'b0, fsp_pkg::OFS_STATE, 32'h0000_0000);
      while (rv[0] !== 1'b0) axi(1'b0, fsp_pkg::OFS_STATE, 32'h0000_0000);
   endtask
   // Reset state and refused accesses
   task automatic t_reset;
      axi(1'b0, fsp_pkg::OFS_LAYOUT, 32'h0000_0000);
      chk("reset layout", 32'h0000_0001, rv & 32'h0000_0007);
      axi(1'b0, 8'h18, 32'h0000_0000);
      chk("unmapped read", {30'h0, fsp_pkg::RESP_SLVERR}, {30'h0, rs});
      axi(1'b1, fsp_pkg::OFS_SR, 32'hFFFF_FFFF);
      chk("read-only write", {30'h0, fsp_pkg::RESP_SLVERR}, {30'h0, rs});
      axi(1'b1, fsp_pkg::OFS_ADDR, 32'h0000_0000);
      $display("reset test done");
   endtask
   // Status words: masking, flags, not ready, stale supply
   task automatic t_status;
      logic [15:0] sv [3] = '{16'hFFFF, 16'h00AA, 16'hFF4F};
      logic [31:0] ev [3] = '{32'h0000_00FE, 32'h0000_00AA, 32'h0};
      for (int i = 0; i < 3; i++) begin
         sr_val <= sv[i];
         run_op(fsp_pkg::OP_STATUS);
         chk("bad sequence", {31'h0, i == 0}, {31'h0, rv[3]});
         axi(1'b0, fsp_pkg::OFS_SR, 32'h0000_0000);
         chk("status", ev[i], rv);
      end
      sr_val <= 16'h0088;
      axi(1'b0, fsp_pkg::OFS_SR, 32'h0000_0000);
      chk("status kept", 32'h0000_0000, rv);
      $display("status test done");
   endtask
   // Poll through busy reads until ready
   task automatic t_poll;
      busy_reads <= 4'h5;
      sr_val     <= 16'h00C4;
      run_op(fsp_pkg::OP_POLL);
      chk("poll done", 32'h0000_0002, rv & 32'h0000_0003);
      axi(1'b0, fsp_pkg::OFS_SR, 32'h0000_0000);
      chk("polled status", 32'h0000_00C4, rv);
      busy_reads <= 4'h0;
      $display("poll test done");
   endtask
   // Buffer check, late availability and exhaustion
   task automatic t_buf;
      logic [3:0] after [2] = '{4'h7, 4'hF};
      xsr_val <= 16'h7F7F;
      for (int i = 0; i < 2; i++) begin
         buf_after <= after[i];
         clr       <= 1'b1;
         @(posedge aclk);
         clr <= 1'b0;
         run_op(fsp_pkg::OP_BUFCHK);
         chk("buffer fail", {31'h0, i == 1}, {31'h0, rv[2]});
         axi(1'b0, fsp_pkg::OFS_XSR, 32'h0000_0000);
         chk("ext status", i == 0 ? 32'h80 : 32'h0, rv);
      end
      $display("buffer test done");
   endtask
   // Every layout code read back and decoded
   task automatic t_layout;
      logic [2:0]  lv;
      logic [31:0] e;
      for (int v = 0; v < 8; v++) begin
         lv = 3'(v);
         pcr_val <= {5'h1F, lv, 8'hFF};
         run_op(fsp_pkg::OP_LAYOUT);
         axi(1'b0, fsp_pkg::OFS_LAYOUT, 32'h0000_0000);
         e = {22'h0, lv != 0, lv != 0, 2'h0, 2'($countones(lv)), 1'b0, lv};
         chk("layout", e, rv);
      end
      $display("layout test done");
   endtask
   // Verdict and end of run
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         failures++;
         close_out();
      end
   end
   // Main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_status();
      t_poll();
      t_buf();
      t_layout();
      close_out();
   end
endmodule
